// [dv/field_model.sv]
// Far side of the sequencer: airflow proving switch and compressor current sense.
// Assumes hp_open comes from the bench to open the series high pressure switch.
`timescale 1ns/1ps

module field_model (
	// Clock
	input wire logic ref_clk,
	// From the bench (indoor fan) and the controller (compressor run)
	input wire logic indoor_fan_on,
	input wire logic [1:0] compressor_run,
	// Fault injection
	input wire logic [1:0] hp_open,
	// To the controller
	output logic airflow_proven,
	output logic [1:0] compressor_current_ok
);
	always @(posedge ref_clk) begin
		// Airflow proves one cycle after the fan starts
		airflow_proven <= indoor_fan_on;
		// Open switch in series cuts contactor current
		compressor_current_ok <= compressor_run & ~hp_open;
	end
endmodule

// [dv/hvac_protection_sequencer_monitor.sv]
// Port-level checker for the protection sequencer.
// Assumes one clock domain and outputs registered at most two cycles behind inputs.
`timescale 1ns/1ps
`include "hvac_defines.svh"

module hvac_seq_monitor (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// Field inputs
	input wire logic estop_closed,
	input wire logic smoke_alarm,
	input wire logic options_module_present,
	input wire logic phase_ok,
	input wire logic indoor_fan_on,
	input wire logic coil_frost_switch,
	input wire logic [1:0] compressor_disable_input,
	input wire logic zone_reset_req,
	input wire logic bas_reset_req,
	// Outputs
	input wire logic [1:0] compressor_run,
	input wire logic exhaust_fan_on,
	input wire logic unit_enable,
	input wire logic lead_circuit,
	input wire logic phase_red_led,
	input wire logic phase_green_led
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_estop_open;
		!estop_closed;
	endsequence
	// Contacts healthy again but nobody asks for a reset
	sequence s_quiet;
		estop_closed && !zone_reset_req && !bas_reset_req && !reg_wr;
	endsequence

	property p_estop_latch;
		s_estop_open ##1 s_quiet [*4] |-> !unit_enable;
	endproperty
	property p_estop_stop;
		s_estop_open [*3] |-> !unit_enable;
	endproperty
	property p_smoke;
		(smoke_alarm && options_module_present) [*3] |-> !unit_enable;
	endproperty
	property p_phase;
		(!phase_ok) [*3] |-> !unit_enable && compressor_run == 2'b00 && phase_red_led;
	endproperty
	property p_led_excl;
		!(phase_red_led && phase_green_led);
	endproperty
	property p_rd_only;
		reg_rdata != 32'h0 |-> $past(reg_rd);
	endproperty
	property p_sp_width;
		$past(reg_rd) && $past(reg_addr) == `REG_EXH_SP |-> reg_rdata[31:7] == 25'h0;
	endproperty
	property p_fan_off;
		(!indoor_fan_on) [*3] |-> !exhaust_fan_on;
	endproperty
	property p_lead_pwrup;
		$fell(rst) |-> (!lead_circuit) [*3];
	endproperty
	property p_frost_inhibit;
		coil_frost_switch [*3] |-> !$rose(compressor_run[0]) && !$rose(compressor_run[1]);
	endproperty
	property p_disable_inhibit;
		(!compressor_disable_input[0]) [*3] |-> !$rose(compressor_run[0]);
	endproperty

	a_estop_latch: assert property (p_estop_latch) else $error("estop latch released");
	a_estop_stop: assert property (p_estop_stop) else $error("estop did not stop unit");
	a_smoke: assert property (p_smoke) else $error("smoke did not stop unit");
	a_phase: assert property (p_phase) else $error("phase fault not blocking");
	a_led_excl: assert property (p_led_excl) else $error("both phase lamps lit");
	a_rd_only: assert property (p_rd_only) else $error("read data outside read slot");
	a_sp_width: assert property (p_sp_width) else $error("setpoint upper bits set");
	a_fan_off: assert property (p_fan_off) else $error("exhaust on with fan off");
	a_lead_pwrup: assert property (p_lead_pwrup) else $error("lead not circuit one");
	a_frost_inhibit: assert property (p_frost_inhibit) else $error("start on frost");
	a_disable_inhibit: assert property (p_disable_inhibit) else $error("start disabled");
endmodule

bind hvac_protection_sequencer hvac_seq_monitor u_hvac_seq_monitor (
	.ref_clk(ref_clk),
	.rst(rst),
	.reg_addr(reg_addr),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_rdata(reg_rdata),
	.estop_closed(estop_closed),
	.smoke_alarm(smoke_alarm),
	.options_module_present(options_module_present),
	.phase_ok(phase_ok),
	.indoor_fan_on(indoor_fan_on),
	.coil_frost_switch(coil_frost_switch),
	.compressor_disable_input(compressor_disable_input),
	.zone_reset_req(zone_reset_req),
	.bas_reset_req(bas_reset_req),
	.compressor_run(compressor_run),
	.exhaust_fan_on(exhaust_fan_on),
	.unit_enable(unit_enable),
	.lead_circuit(lead_circuit),
	.phase_red_led(phase_red_led),
	.phase_green_led(phase_green_led)
);

// [dv/tb_hvac_protection_sequencer.sv]
// Self-checking bench for the protection sequencer with its field model.
// Assumes TICK_CYCLES shortened to 2, so one second is 2000 clocks.
`timescale 1ns/1ps
`include "hvac_defines.svh"

module tb_hvac_protection_sequencer;
	localparam int TK = 2;
	localparam int SEC = TK * 1000;
	logic ref_clk, rst, reg_wr, reg_rd, rd_pend;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic ovf, estop_closed, smoke_alarm, opt_present, phase_ok, airflow_proven;
	logic indoor_fan_on, leadlag_select_open, heat_call, coil_frost_switch;
	logic [6:0] damper_pos, sp;
	logic [1:0] cool_call, dis_in, lp_in, cur_ok, hp_open, compressor_run;
	logic zone_reset_req, bas_reset_req, exhaust_fan_on, unit_enable, lead_circuit;
	logic red, green, zone_heat, zone_cool, zone_system_on, zone_service;
	int n_errors, checked;
	logic [31:0] exp_q[$], msk_q[$];

	hvac_protection_sequencer #(.TICK_CYCLES(TK)) u_hvac_protection_sequencer (
		.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.condensate_overflow_switch(ovf), .estop_closed(estop_closed),
		.smoke_alarm(smoke_alarm), .options_module_present(opt_present),
		.phase_ok(phase_ok), .airflow_proven(airflow_proven),
		.indoor_fan_on(indoor_fan_on), .damper_pos(damper_pos),
		.leadlag_select_open(leadlag_select_open), .heat_call(heat_call),
		.cool_stage_call(cool_call), .coil_frost_switch(coil_frost_switch),
		.compressor_disable_input(dis_in), .low_pressure_switch(lp_in),
		.compressor_current_ok(cur_ok), .zone_reset_req(zone_reset_req),
		.bas_reset_req(bas_reset_req), .compressor_run(compressor_run),
		.exhaust_fan_on(exhaust_fan_on), .unit_enable(unit_enable),
		.lead_circuit(lead_circuit), .phase_red_led(red), .phase_green_led(green),
		.zone_heat(zone_heat), .zone_cool(zone_cool), .zone_system_on(zone_system_on),
		.zone_service(zone_service));

	field_model u_field_model (.ref_clk(ref_clk), .indoor_fan_on(indoor_fan_on),
		.compressor_run(compressor_run), .hp_open(hp_open),
		.airflow_proven(airflow_proven), .compressor_current_ok(cur_ok));

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// Ends at a falling edge so outputs are settled when looked at
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		exp_q.push_back(e);
		msk_q.push_back(m);
		@(posedge ref_clk);
		reg_rd <= 1'b0;
	endtask

	task automatic pulse_reset(input bit from_bas);
		@(posedge ref_clk);
		if (from_bas) bas_reset_req <= 1'b1;
		else zone_reset_req <= 1'b1;
		@(posedge ref_clk);
		{zone_reset_req, bas_reset_req} <= 2'b00;
		cyc(4);
	endtask

	task automatic try_start(input logic [1:0] d, input logic f, input logic e);
		@(posedge ref_clk);
		dis_in <= d;
		coil_frost_switch <= f;
		cool_call <= 2'b01;
		cyc(6);
		check("compressor_run0", {compressor_run[0], zone_cool}, {e, e});
		@(posedge ref_clk);
		cool_call <= 2'b00;
		{dis_in, coil_frost_switch} <= 3'b110;
		cyc(4);
	endtask

	// Read data stands only in the cycle after the strobe
	always @(negedge ref_clk) begin
		if (rd_pend) check("reg_rdata", reg_rdata & msk_q.pop_front(), exp_q.pop_front());
		rd_pend = reg_rd;
	end

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	initial begin
		repeat (80000) @(posedge ref_clk);
		n_errors++;
		$display("MISMATCH watchdog expected done seen timeout");
		tally_and_finish();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		{reg_wr, reg_rd, ovf, smoke_alarm, indoor_fan_on, leadlag_select_open} = '0;
		{heat_call, coil_frost_switch, zone_reset_req, bas_reset_req} = '0;
		{reg_addr, reg_wdata, damper_pos, cool_call, hp_open} = '0;
		{estop_closed, phase_ok, opt_present, dis_in, lp_in} = 7'h7F;
		void'($urandom(12));
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		cyc(2);
		check("lead_circuit", lead_circuit, 1'b0);
		rd(`REG_EXH_SP, 32'h19, 32'hFFFFFFFF);
		rd(`REG_CTRL, 32'h0, 32'hFFFFFFFF);
		rd(8'h0C, 32'h0, 32'hFFFFFFFF);
		sp = 7'($urandom_range(10, 90));
		wr(`REG_EXH_SP, {25'h0, sp});
		@(posedge ref_clk);
		indoor_fan_on <= 1'b1;
		damper_pos <= sp - 7'h1;
		cyc(4);
		check("exhaust_below", exhaust_fan_on, 1'b0);
		@(posedge ref_clk);
		damper_pos <= sp;
		cyc(4);
		check("exhaust_at", exhaust_fan_on, 1'b1);
		@(posedge ref_clk);
		indoor_fan_on <= 1'b0;
		cyc(4);
		check("exhaust_fan_off", exhaust_fan_on, 1'b0);
		try_start(2'b10, 1'b0, 1'b0);
		try_start(2'b11, 1'b1, 1'b0);
		try_start(2'b11, 1'b0, 1'b1);
		check("lead_fixed", lead_circuit, 1'b0);
		// Brief closure restarts the debounce, then a full second trips
		@(posedge ref_clk);
		cool_call <= 2'b01;
		cyc(6);
		@(posedge ref_clk);
		lp_in <= 2'b10;
		cyc(SEC - 20);
		check("run_before_qual", compressor_run[0], 1'b1);
		@(posedge ref_clk);
		lp_in <= 2'b11;
		@(posedge ref_clk);
		lp_in <= 2'b10;
		cyc(SEC + 20);
		check("run_after_trip", compressor_run, 2'b00);
		@(posedge ref_clk);
		lp_in <= 2'b11;
		cyc(SEC);
		check("held_off", compressor_run[0], 1'b0);
		rd(`REG_STATUS, 32'h1000, 32'h3400);
		wr(`REG_CTRL, 32'h1);
		cyc(6);
		check("run_after_reset", compressor_run[0], 1'b1);
		@(posedge ref_clk);
		hp_open <= 2'b01;
		cyc(SEC + 50);
		check("hp_lockout", {compressor_run[0], zone_service}, 2'b01);
		rd(`REG_STATUS, 32'h0400, 32'h0400);
		@(posedge ref_clk);
		{hp_open, cool_call} <= 4'h0;
		pulse_reset(1'b0);
		rd(`REG_STATUS, 32'h0, 32'h0400);
		@(posedge ref_clk);
		estop_closed <= 1'b0;
		cyc(4);
		check("estop_stop", unit_enable, 1'b0);
		@(posedge ref_clk);
		estop_closed <= 1'b1;
		cyc(20);
		check("estop_held", {unit_enable, zone_service}, 2'b01);
		pulse_reset(1'b0);
		check("estop_cleared", unit_enable, 1'b1);
		@(posedge ref_clk);
		{opt_present, smoke_alarm} <= 2'b01;
		cyc(8);
		check("smoke_no_module", unit_enable, 1'b1);
		@(posedge ref_clk);
		opt_present <= 1'b1;
		cyc(4);
		@(posedge ref_clk);
		smoke_alarm <= 1'b0;
		cyc(10);
		check("smoke_held", unit_enable, 1'b0);
		pulse_reset(1'b1);
		check("smoke_cleared", unit_enable, 1'b1);
		@(posedge ref_clk);
		phase_ok <= 1'b0;
		heat_call <= 1'b1;
		cyc(4);
		check("phase_fault", {red, green, unit_enable, zone_system_on}, 4'b1000);
		@(posedge ref_clk);
		phase_ok <= 1'b1;
		cyc(4);
		check("phase_good", {red, green, unit_enable, zone_system_on}, 4'b0111);
		check("zone_heat", zone_heat, 1'b1);
		@(posedge ref_clk);
		{heat_call, ovf} <= 2'b01;
		cyc(6 * SEC - 40);
		check("ovf_short", unit_enable, 1'b1);
		@(posedge ref_clk);
		ovf <= 1'b0;
		@(posedge ref_clk);
		ovf <= 1'b1;
		cyc(6 * SEC + 40);
		check("ovf_halt", unit_enable, 1'b0);
		rd(`REG_STATUS, 32'h1, 32'h3);
		@(posedge ref_clk);
		ovf <= 1'b0;
		cyc(6 * SEC - 40);
		check("ovf_still_halted", unit_enable, 1'b0);
		cyc(80);
		check("ovf_restored", unit_enable, 1'b1);
		@(posedge ref_clk);
		leadlag_select_open <= 1'b1;
		try_start(2'b11, 1'b0, 1'b1);
		check("lead_swapped", lead_circuit, 1'b1);
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		cyc(2);
		check("lead_after_power_up", lead_circuit, 1'b0);
		tally_and_finish();
	end
endmodule

// [logic/circuit_guard.sv]
// One refrigeration circuit: start inhibits, trip qualification, restart delay,
// trip counting and lockout. Assumes ms and s ticks are one-cycle enables.
`timescale 1ns/1ps
`include "hvac_defines.svh"

module circuit_guard (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Timebase
	input wire logic ms_tick,
	input wire logic s_tick,
	// Unit level
	input wire logic unit_ok,
	input wire logic manual_reset,
	// Circuit inputs and results
	input wire hvac_pkg::ckt_in_s ci,
	output hvac_pkg::ckt_out_s co
);

	logic run_r;
	logic lock_r;
	logic stop_r;
	logic [7:0] dly_r;
	logic [7:0] run_s_r;
	logic [2:0] early_r;
	logic [2:0] lpcnt_r;
	logic [3:0] cond;
	logic [3:0] qual;
	logic [12:0] qcnt_r [4];
	logic fault_now;
	logic trip;
	logic start_ok;
	logic lock_set;

	////////////////////////////////////////////////////////////////////////////
	// Continuous-time qualification while running

	assign cond[0] = !ci.disable_closed;
	assign cond[1] = !ci.lp_closed;
	assign cond[2] = ci.frost_closed;
	assign cond[3] = !ci.current_ok;

	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_qual
			always_ff @(posedge clk) begin
				// Any interruption restarts the count
				if (rst || !run_r || !cond[i]) begin
					qcnt_r[i] <= 13'h0000;
				end else if (ms_tick && qcnt_r[i] != 13'(`TRIP_QUAL_MS)) begin
					qcnt_r[i] <= qcnt_r[i] + 13'h0001;
				end
			end
			assign qual[i] = (qcnt_r[i] == 13'(`TRIP_QUAL_MS));
		end
	endgenerate

	assign fault_now = cond[0] || cond[1] || cond[2];
	assign trip = run_r && (qual[0] || qual[1] || qual[2]);
	assign start_ok = ci.call && unit_ok && !lock_r && (dly_r == 8'h00) && !fault_now;

	////////////////////////////////////////////////////////////////////////////
	// Run state

	always_ff @(posedge clk) begin
		if (rst) begin
			run_r <= 1'b0;
		end else if (run_r) begin
			if (trip || qual[3] || !ci.call || !unit_ok || lock_r) begin
				run_r <= 1'b0;
			end
		end else if (start_ok) begin
			run_r <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			stop_r <= 1'b0;
		end else begin
			stop_r <= run_r && !ci.call && !trip && !qual[3];
		end
	end

	always_ff @(posedge clk) begin
		if (rst || !run_r) begin
			run_s_r <= 8'h00;
		end else if (s_tick && run_s_r != 8'(`EARLY_RUN_S)) begin
			run_s_r <= run_s_r + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Restart delay: held full while faulty; a spare second covers the free s tick phase

	always_ff @(posedge clk) begin
		if (rst) begin
			dly_r <= 8'h00;
		end else if (trip || (fault_now && dly_r != 8'h00)) begin
			dly_r <= 8'(`RESTART_DLY_S + 1);
		end else if (manual_reset && !fault_now) begin
			dly_r <= 8'h00;
		end else if (s_tick && dly_r != 8'h00) begin
			dly_r <= dly_r - 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Consecutive trip counters and lockout

	always_ff @(posedge clk) begin
		if (rst) begin
			early_r <= 3'h0;
		end else if (trip && (qual[0] || qual[1]) && run_s_r != 8'(`EARLY_RUN_S)) begin
			early_r <= early_r + 3'h1;
		end else if (run_s_r == 8'(`EARLY_RUN_S) || (manual_reset && !fault_now)) begin
			early_r <= 3'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			lpcnt_r <= 3'h0;
		end else if (trip && qual[1]) begin
			lpcnt_r <= lpcnt_r + 3'h1;
		end else if (!ci.call || (manual_reset && !fault_now)) begin
			lpcnt_r <= 3'h0;
		end
	end

	assign lock_set = (trip && (qual[0] || qual[1]) && run_s_r != 8'(`EARLY_RUN_S)
		&& early_r == 3'(`TRIP_LIMIT - 1))
		|| (trip && qual[1] && lpcnt_r == 3'(`TRIP_LIMIT - 1))
		|| (run_r && ci.call && qual[3]);

	always_ff @(posedge clk) begin
		if (rst) begin
			lock_r <= 1'b0;
		end else if (lock_set) begin
			lock_r <= 1'b1;
		end else if (manual_reset && !fault_now) begin
			lock_r <= 1'b0;
		end
	end

	assign co.run = run_r;
	assign co.lockout = lock_r;
	assign co.restart_wait = (dly_r != 8'h00);
	assign co.satisfied_stop = stop_r;

endmodule

// [logic/hvac_defines.svh]
// Constants of the rooftop protection sequencer: times, limits, register map.
// Included by the design modules and the testbench; definitions only.
`ifndef HVAC_DEFINES_SVH
`define HVAC_DEFINES_SVH

// Timebase
`define CLK_HZ 125000000
`define MS_PER_S 1000
`define TICK_CYCLES_DEF (`CLK_HZ / 1000)

// Qualification and delay times in their own units
`define OVF_QUAL_S 6
`define OVF_QUAL_MS (`OVF_QUAL_S * `MS_PER_S)
`define TRIP_QUAL_S 1
`define TRIP_QUAL_MS (`TRIP_QUAL_S * `MS_PER_S)
`define HP_QUAL_S 1
`define HP_QUAL_MS (`HP_QUAL_S * `MS_PER_S)
`define RESTART_DLY_MIN 3
`define RESTART_DLY_S (`RESTART_DLY_MIN * 60)
`define EARLY_RUN_MIN 3
`define EARLY_RUN_S (`EARLY_RUN_MIN * 60)
`define AIRFLOW_S 40
`define OVF_WINDOW_DAYS 3
`define OVF_WINDOW_S (`OVF_WINDOW_DAYS * 86400)

// Fault limits
`define TRIP_LIMIT 4
`define OVF_LIMIT 2

// Register map (byte addresses) and fields
`define REG_CTRL 8'h00
`define REG_EXH_SP 8'h04
`define REG_STATUS 8'h08
`define CTRL_RESET_BIT 0
`define EXH_SP_RST 7'h19

`endif

// [logic/hvac_pkg.sv]
// Types shared by the sequencer top and its per-circuit guard.
// Assumes hvac_defines.svh on the include path.
package hvac_pkg;

	typedef enum logic [1:0] {
		OVF_NORMAL = 2'b00,
		OVF_SHUT = 2'b01,
		OVF_LOCK = 2'b10
	} ovf_state_e;

	typedef struct packed {
		logic call;
		logic disable_closed;
		logic lp_closed;
		logic frost_closed;
		logic current_ok;
	} ckt_in_s;

	typedef struct packed {
		logic run;
		logic lockout;
		logic restart_wait;
		logic satisfied_stop;
	} ckt_out_s;

endpackage

// [logic/hvac_protection_sequencer.sv]
// Rooftop unit protection and sequencing: overflow, emergency stop, smoke,
// phase, airflow, exhaust fan, lead/lag, zone status and a small register port.
// Assumes all field inputs are already synchronous to ref_clk.
//
// Summary of operation
// - Overflow tripped 6 s continuously halts all unit functions while it lasts.
// - Normal operation returns after overflow stays clear 6 s continuously.
// - More than 2 overflow shutdowns in 3 days latch a manual-reset lockout.
// - Power cycle also clears the overflow lockout.
// - Compressor may not start while its disable input is open.
// - Disable or low pressure open 1 s while running stops that compressor.
// - After a trip the compressor stays off at least 3 minutes, unless a manual reset clears the delay.
// - Four consecutive opens in first three minutes lock circuit, report, manual reset.
// - Four low pressure opens in one cooling call lock that circuit only.
// - No compressor current while cooling called locks that compressor.
// - With indoor fan on, exhaust fan runs when damper reaches setpoint, default 25%.
// - Lead/lag rotation off unless selection input is open.
// - With rotation, lead swaps each time lead stops on satisfied load.
// - Circuit one leads after every power-up.
// - Compressor may not start while frost switch is closed.
// - Frost closed 1 s stops compressor; off 3 minutes after it reopens.
// - Emergency stop open shuts unit down until manual reset.
// - Smoke with options module fitted latches shutdown until manual reset.
// - Phase fault blocks operation and lights red; green marks healthy supply.
// - Four zone status outputs: heating, cooling, system on, service.
// - Airflow unproven 40 s locks all mechanics, reports, flashes service.
`timescale 1ns/1ps
`include "hvac_defines.svh"

module hvac_protection_sequencer #(
	parameter int unsigned TICK_CYCLES = `TICK_CYCLES_DEF
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Unit-level field inputs
	input wire logic condensate_overflow_switch,
	input wire logic estop_closed,
	input wire logic smoke_alarm,
	input wire logic options_module_present,
	input wire logic phase_ok,
	input wire logic airflow_proven,
	input wire logic indoor_fan_on,
	input wire logic [6:0] damper_pos,
	input wire logic leadlag_select_open,
	input wire logic heat_call,
	input wire logic [1:0] cool_stage_call,
	input wire logic coil_frost_switch,
	// Per-circuit field inputs
	input wire logic [1:0] compressor_disable_input,
	input wire logic [1:0] low_pressure_switch,
	input wire logic [1:0] compressor_current_ok,
	// Manual reset requests
	input wire logic zone_reset_req,
	input wire logic bas_reset_req,
	// Outputs
	output logic [1:0] compressor_run,
	output logic exhaust_fan_on,
	output logic unit_enable,
	output logic lead_circuit,
	output logic phase_red_led,
	output logic phase_green_led,
	output logic zone_heat,
	output logic zone_cool,
	output logic zone_system_on,
	output logic zone_service
);

	logic [16:0] tick_cnt_r;
	logic [9:0] ms_cnt_r;
	logic ms_tick;
	logic s_tick;
	logic ctrl_reset;
	logic manual_reset;
	logic [6:0] exh_sp_r;
	logic [31:0] status;
	hvac_pkg::ovf_state_e ovf_state_r;
	logic [12:0] ovf_cnt_r;
	logic [1:0] ovf_shut_cnt_r;
	logic [17:0] ovf_win_r;
	logic ovf_qual;
	logic estop_lock_r;
	logic smoke_lock_r;
	logic air_lock_r;
	logic [5:0] air_cnt_r;
	logic flash_r;
	logic lead_r;
	logic unit_ok;
	logic rot_en;
	hvac_pkg::ckt_in_s ci [2];
	hvac_pkg::ckt_out_s co [2];

	////////////////////////////////////////////////////////////////////////////
	// Timebase: ms and s enables

	always_ff @(posedge ref_clk) begin
		if (rst || ms_tick) begin
			tick_cnt_r <= 17'h00000;
		end else begin
			tick_cnt_r <= tick_cnt_r + 17'h00001;
		end
	end

	assign ms_tick = (tick_cnt_r == 17'(TICK_CYCLES - 1));

	always_ff @(posedge ref_clk) begin
		if (rst || s_tick) begin
			ms_cnt_r <= 10'h000;
		end else if (ms_tick) begin
			ms_cnt_r <= ms_cnt_r + 10'h001;
		end
	end

	assign s_tick = ms_tick && (ms_cnt_r == 10'(`MS_PER_S - 1));

	////////////////////////////////////////////////////////////////////////////
	// Register port

	assign ctrl_reset = reg_wr && reg_addr == `REG_CTRL && reg_wdata[`CTRL_RESET_BIT];
	assign manual_reset = zone_reset_req || bas_reset_req || ctrl_reset;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			exh_sp_r <= `EXH_SP_RST;
		end else if (reg_wr && reg_addr == `REG_EXH_SP) begin
			exh_sp_r <= reg_wdata[6:0];
		end
	end

	assign status = {17'h00000, exhaust_fan_on, co[1].restart_wait, co[0].restart_wait,
		co[1].lockout, co[0].lockout, co[1].run, co[0].run, rot_en, lead_r,
		!phase_ok, air_lock_r, smoke_lock_r, estop_lock_r,
		ovf_state_r == hvac_pkg::OVF_LOCK, ovf_state_r != hvac_pkg::OVF_NORMAL};

	always_ff @(posedge ref_clk) begin
		if (rst || !reg_rd) begin
			reg_rdata <= 32'h00000000;
		end else begin
			case (reg_addr)
				`REG_CTRL: reg_rdata <= 32'h00000000;
				`REG_EXH_SP: reg_rdata <= {25'h0000000, exh_sp_r};
				`REG_STATUS: reg_rdata <= status;
				default: reg_rdata <= 32'h00000000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Condensate overflow

	// Count runs toward whichever level would change the state
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ovf_cnt_r <= 13'h0000;
		end else if ((ovf_state_r == hvac_pkg::OVF_NORMAL) != condensate_overflow_switch
			|| ovf_qual) begin
			ovf_cnt_r <= 13'h0000;
		end else if (ms_tick) begin
			ovf_cnt_r <= ovf_cnt_r + 13'h0001;
		end
	end

	assign ovf_qual = (ovf_cnt_r == 13'(`OVF_QUAL_MS));

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ovf_state_r <= hvac_pkg::OVF_NORMAL;
		end else begin
			case (ovf_state_r)
				hvac_pkg::OVF_NORMAL: begin
					if (ovf_qual && ovf_shut_cnt_r == 2'(`OVF_LIMIT)) begin
						ovf_state_r <= hvac_pkg::OVF_LOCK;
					end else if (ovf_qual) begin
						ovf_state_r <= hvac_pkg::OVF_SHUT;
					end
				end
				hvac_pkg::OVF_SHUT: begin
					if (ovf_qual) begin
						ovf_state_r <= hvac_pkg::OVF_NORMAL;
					end
				end
				hvac_pkg::OVF_LOCK: begin
					if (manual_reset && !condensate_overflow_switch) begin
						ovf_state_r <= hvac_pkg::OVF_NORMAL;
					end
				end
				default: ovf_state_r <= hvac_pkg::OVF_NORMAL;
			endcase
		end
	end

	// Window opens at the first shutdown and discards the count when it expires
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ovf_shut_cnt_r <= 2'h0;
		end else if (ovf_state_r == hvac_pkg::OVF_NORMAL && ovf_qual) begin
			if (ovf_shut_cnt_r != 2'(`OVF_LIMIT)) begin
				ovf_shut_cnt_r <= ovf_shut_cnt_r + 2'h1;
			end
		end else if (ovf_win_r == 18'(`OVF_WINDOW_S)
			|| (ovf_state_r == hvac_pkg::OVF_LOCK && manual_reset
			&& !condensate_overflow_switch)) begin
			ovf_shut_cnt_r <= 2'h0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst || ovf_shut_cnt_r == 2'h0 || ovf_win_r == 18'(`OVF_WINDOW_S)) begin
			ovf_win_r <= 18'h00000;
		end else if (s_tick) begin
			ovf_win_r <= ovf_win_r + 18'h00001;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Unit shutdown latches

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			estop_lock_r <= 1'b0;
		end else if (!estop_closed) begin
			estop_lock_r <= 1'b1;
		end else if (manual_reset) begin
			estop_lock_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			smoke_lock_r <= 1'b0;
		end else if (options_module_present && smoke_alarm) begin
			smoke_lock_r <= 1'b1;
		end else if (manual_reset) begin
			smoke_lock_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst || !indoor_fan_on || airflow_proven) begin
			air_cnt_r <= 6'h00;
		end else if (s_tick && air_cnt_r != 6'(`AIRFLOW_S)) begin
			air_cnt_r <= air_cnt_r + 6'h01;
		end
	end

	// Clearing waits for proven airflow or fan off; until then the count held at 40 s sets the lock again
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			air_lock_r <= 1'b0;
		end else if (air_cnt_r == 6'(`AIRFLOW_S)) begin
			air_lock_r <= 1'b1;
		end else if (manual_reset) begin
			air_lock_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			flash_r <= 1'b0;
		end else if (s_tick) begin
			flash_r <= !flash_r;
		end
	end

	assign unit_ok = phase_ok && ovf_state_r == hvac_pkg::OVF_NORMAL
		&& !estop_lock_r && !smoke_lock_r && !air_lock_r;

	////////////////////////////////////////////////////////////////////////////
	// Lead/lag and circuits

	assign rot_en = leadlag_select_open;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			lead_r <= 1'b0;
		end else if (rot_en && co[lead_r].satisfied_stop) begin
			lead_r <= !lead_r;
		end
	end

	genvar c;
	generate
		for (c = 0; c < 2; c++) begin : g_ckt
			// Stage one goes to the lead circuit, stage two to the lag
			assign ci[c].call = (lead_r == 1'(c)) ? cool_stage_call[0] : cool_stage_call[1];
			assign ci[c].disable_closed = compressor_disable_input[c];
			assign ci[c].lp_closed = low_pressure_switch[c];
			assign ci[c].frost_closed = coil_frost_switch;
			assign ci[c].current_ok = compressor_current_ok[c];

			circuit_guard u_guard (
				.clk(ref_clk),
				.rst(rst),
				.ms_tick(ms_tick),
				.s_tick(s_tick),
				.unit_ok(unit_ok),
				.manual_reset(manual_reset),
				.ci(ci[c]),
				.co(co[c])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			compressor_run <= 2'b00;
			exhaust_fan_on <= 1'b0;
			unit_enable <= 1'b0;
			lead_circuit <= 1'b0;
			phase_red_led <= 1'b0;
			phase_green_led <= 1'b0;
		end else begin
			compressor_run <= {co[1].run, co[0].run};
			exhaust_fan_on <= unit_ok && indoor_fan_on && damper_pos >= exh_sp_r;
			unit_enable <= unit_ok;
			lead_circuit <= lead_r;
			phase_red_led <= !phase_ok;
			phase_green_led <= phase_ok;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			zone_heat <= 1'b0;
			zone_cool <= 1'b0;
			zone_system_on <= 1'b0;
			zone_service <= 1'b0;
		end else begin
			zone_heat <= unit_ok && heat_call;
			zone_cool <= co[0].run || co[1].run;
			zone_system_on <= unit_ok;
			zone_service <= air_lock_r ? flash_r : (co[0].lockout || co[1].lockout
				|| ovf_state_r == hvac_pkg::OVF_LOCK || estop_lock_r || smoke_lock_r);
		end
	end

endmodule
